// File: cald_datapath.sv
// Purpose: arithmetic and logic datapath with register file and status byte
// Assumes: decode logic on core_clk drives the op port; io space on same clock
// Notes:   byte ops finish at the accepting edge, word and io ops one edge later
`include "cald_map.svh"
`default_nettype none

// Summary of operation
// - add two registers plus carry, one clock
// - word add immediate on pair, two clocks
// - word subtract immediate on pair, two clocks
// - subtract constant from register, one clock
// - register minus register minus carry, one clock
// - register minus constant minus carry, one clock
// - and with constant, flags z n v
// - or constant mask, flags z n v
// - and with inverted mask, flags z n v
// - some io flags clear on written one
// - io bit ops rewrite whole io register
// - io bit ops reach addresses 00 to 1F
module cald_datapath (
   input  wire logic                    core_clk,
   input  wire logic                    arst_n,
   // operation request from decode
   input  wire logic                    opValid,
   output logic                         opReady,
   input  wire cald_pkg::cald_op_t      opCode,
   input  wire logic [`CALD_REG_AW-1:0] dstSel,
   input  wire logic [`CALD_REG_AW-1:0] srcSel,
   input  wire logic [7:0]              immValue,
   input  wire logic [5:0]              ioAddr,
   input  wire logic [2:0]              ioBitIndex,
   output logic                         opDone,
   output logic                         opReject,
   // register file load and peek port
   input  wire logic                    regLoadEn,
   input  wire logic [`CALD_REG_AW-1:0] regLoadAddr,
   input  wire logic [7:0]              regLoadData,
   input  wire logic [`CALD_REG_AW-1:0] regPeekAddr,
   output logic [7:0]                   regPeekData,
   // status byte
   output logic [7:0]                   statusFlags,
   // io space
   output logic [5:0]                   ioRdAddr,
   input  wire logic [7:0]              ioRdData,
   output logic                         ioWrEn,
   output logic [5:0]                   ioWrAddr,
   output logic [7:0]                   ioWrData
);

   function automatic logic isWordOp(input cald_pkg::cald_op_t op);
      return (op == cald_pkg::OP_WORD_ADD_IMMEDIATE) ||
             (op == cald_pkg::OP_WORD_SUBTRACT_IMMEDIATE);
   endfunction : isWordOp

   function automatic logic isIoOp(input cald_pkg::cald_op_t op);
      return (op == cald_pkg::OP_IO_BIT_SET) || (op == cald_pkg::OP_IO_BIT_CLEAR);
   endfunction : isIoOp

   cald_pkg::cald_state_t state_q;
   cald_pkg::cald_state_t state_d;

   logic [7:0]              regs_q [`CALD_REG_COUNT];
   logic [7:0]              flags_q;
   logic [7:0]              flags_d;
   logic                    opDone_q;
   logic                    opReject_q;
   logic                    accept;

   // word op holding state
   logic [`CALD_REG_AW-1:0] pairLo_q;
   logic [7:0]              wordK_q;
   logic                    wordSub_q;
   logic [7:0]              lowRes_q;
   logic                    lowCarry_q;

   // io op holding state
   logic [5:0]              ioAddr_q;
   logic [2:0]              ioBit_q;
   logic                    ioSet_q;
   logic                    ioWrEn_q;
   logic [5:0]              ioWrAddr_q;
   logic [7:0]              ioWrData_q;
   logic                    ioInRange;
   logic [7:0]              ioRmwData;
   logic                    ioReqInRange;
   logic [7:0]              ioReqUnused;

   // byte arithmetic
   logic [7:0]              opA;
   logic [7:0]              opB;
   logic                    cin;
   logic                    isSub;
   logic                    isLogic;
   logic [8:0]              wide;
   logic [4:0]              nib;
   logic [7:0]              res;
   logic                    byteWr;

   // word arithmetic
   logic [`CALD_REG_AW-1:0] pairHi;
   logic [7:0]              hiA;
   logic [8:0]              hiWide;
   logic [15:0]             wordRes;

   assign accept  = opValid && (state_q == cald_pkg::ST_IDLE);
   assign opReady = (state_q == cald_pkg::ST_IDLE);

   // operand and operation selection
   always_comb begin
      opA     = regs_q[dstSel];
      opB     = immValue;
      cin     = 1'b0;
      isSub   = 1'b0;
      isLogic = 1'b0;
      res     = 8'h00;
      case (opCode)
         cald_pkg::OP_ADD: begin
            opB = regs_q[srcSel];
         end
         cald_pkg::OP_ADD_WITH_CARRY: begin
            opB = regs_q[srcSel];
            cin = flags_q[`CALD_FLAG_C];
         end
         cald_pkg::OP_SUBTRACT: begin
            opB   = regs_q[srcSel];
            isSub = 1'b1;
         end
         cald_pkg::OP_SUBTRACT_IMMEDIATE: begin
            isSub = 1'b1;
         end
         cald_pkg::OP_SUBTRACT_WITH_BORROW: begin
            opB   = regs_q[srcSel];
            isSub = 1'b1;
            cin   = flags_q[`CALD_FLAG_C];
         end
         cald_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW: begin
            isSub = 1'b1;
            cin   = flags_q[`CALD_FLAG_C];
         end
         cald_pkg::OP_AND_IMMEDIATE: begin
            isLogic = 1'b1;
            res     = opA & immValue;
         end
         cald_pkg::OP_SET_BITS_IMMEDIATE: begin
            isLogic = 1'b1;
            res     = opA | immValue;
         end
         cald_pkg::OP_CLEAR_BITS_IMMEDIATE: begin
            isLogic = 1'b1;
            res     = opA & (8'hFF - immValue);
         end
         default: begin
         end
      endcase
      if (isSub) begin
         wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
         nib  = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, cin};
      end else begin
         wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
         nib  = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
      end
      if (!isLogic) begin
         res = wide[7:0];
      end
   end

   // codes above the last byte op make no byte write
   assign byteWr = accept && (opCode <= cald_pkg::OP_CLEAR_BITS_IMMEDIATE);

   // high byte of the word op uses the carry of the low byte
   assign pairHi  = pairLo_q + 5'h01;
   assign hiA     = regs_q[pairHi];
   assign hiWide  = wordSub_q ? ({1'b0, hiA} - {8'h00, lowCarry_q})
                              : ({1'b0, hiA} + {8'h00, lowCarry_q});
   assign wordRes = {hiWide[7:0], lowRes_q};

   // flag update; untouched flags keep their value
   always_comb begin
      flags_d = flags_q;
      if (byteWr) begin
         flags_d[`CALD_FLAG_Z] = (res == 8'h00);
         flags_d[`CALD_FLAG_N] = res[7];
         if (isLogic) begin
            flags_d[`CALD_FLAG_V] = 1'b0;
         end else begin
            flags_d[`CALD_FLAG_C] = wide[8];
            flags_d[`CALD_FLAG_H] = nib[4];
            if (isSub) begin
               flags_d[`CALD_FLAG_V] = (opA[7] != opB[7]) && (res[7] != opA[7]);
            end else begin
               flags_d[`CALD_FLAG_V] = (opA[7] == opB[7]) && (res[7] != opA[7]);
            end
         end
      end else if (state_q == cald_pkg::ST_WORD_HI) begin
         flags_d[`CALD_FLAG_Z] = (wordRes == 16'h0000);
         flags_d[`CALD_FLAG_N] = wordRes[15];
         if (wordSub_q) begin
            flags_d[`CALD_FLAG_V] = hiA[7] & ~wordRes[15];
            flags_d[`CALD_FLAG_C] = wordRes[15] & ~hiA[7];
         end else begin
            flags_d[`CALD_FLAG_V] = ~hiA[7] & wordRes[15];
            flags_d[`CALD_FLAG_C] = ~wordRes[15] & hiA[7];
         end
         flags_d[`CALD_FLAG_S] = flags_d[`CALD_FLAG_N] ^ flags_d[`CALD_FLAG_V];
      end
   end

   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         cald_pkg::ST_IDLE: begin
            if (accept && isWordOp(opCode)) begin
               state_d = cald_pkg::ST_WORD_HI;
            end else if (accept && isIoOp(opCode) && ioReqInRange) begin
               state_d = cald_pkg::ST_IO_RMW;
            end
         end
         cald_pkg::ST_WORD_HI: begin
            state_d = cald_pkg::ST_IDLE;
         end
         cald_pkg::ST_IO_RMW: begin
            state_d = cald_pkg::ST_IDLE;
         end
         default: begin
            state_d = cald_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= cald_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= `CALD_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // register file; datapath write wins over a load to the same entry
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `CALD_REG_COUNT; i++) begin
            regs_q[i] <= `CALD_REG_RST;
         end
      end else begin
         if (regLoadEn) begin
            regs_q[regLoadAddr] <= regLoadData;
         end
         if (byteWr) begin
            regs_q[dstSel] <= res;
         end
         if (state_q == cald_pkg::ST_WORD_HI) begin
            regs_q[pairLo_q] <= wordRes[7:0];
            regs_q[pairHi]   <= wordRes[15:8];
         end
      end
   end

   // low byte of the word op, held until the final clock
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pairLo_q   <= '0;
         wordK_q    <= 8'h00;
         wordSub_q  <= 1'b0;
         lowRes_q   <= 8'h00;
         lowCarry_q <= 1'b0;
      end else if (accept && isWordOp(opCode)) begin
         pairLo_q  <= {dstSel[`CALD_REG_AW-1:1], 1'b0};
         wordK_q   <= {2'b00, immValue[5:0]};
         wordSub_q <= (opCode == cald_pkg::OP_WORD_SUBTRACT_IMMEDIATE);
         if (opCode == cald_pkg::OP_WORD_SUBTRACT_IMMEDIATE) begin
            {lowCarry_q, lowRes_q} <= {1'b0, regs_q[{dstSel[`CALD_REG_AW-1:1], 1'b0}]}
                                      - {3'b000, immValue[5:0]};
         end else begin
            {lowCarry_q, lowRes_q} <= {1'b0, regs_q[{dstSel[`CALD_REG_AW-1:1], 1'b0}]}
                                      + {3'b000, immValue[5:0]};
         end
      end
   end

   // io bit set and clear; range checked when taken
   cald_io_bit uReqCheck (
      .ioAddr      (ioAddr),
      .bitIndex    (ioBitIndex),
      .setNotClear (1'b1),
      .rdData      (8'h00),
      .inRange     (ioReqInRange),
      .wrData      (ioReqUnused)
   );

   cald_io_bit uRmw (
      .ioAddr      (ioAddr_q),
      .bitIndex    (ioBit_q),
      .setNotClear (ioSet_q),
      .rdData      (ioRdData),
      .inRange     (ioInRange),
      .wrData      (ioRmwData)
   );

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ioAddr_q <= 6'h00;
         ioBit_q  <= 3'h0;
         ioSet_q  <= 1'b0;
      end else if (accept && isIoOp(opCode)) begin
         ioAddr_q <= ioAddr;
         ioBit_q  <= ioBitIndex;
         ioSet_q  <= (opCode == cald_pkg::OP_IO_BIT_SET);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ioWrEn_q   <= 1'b0;
         ioWrAddr_q <= 6'h00;
         ioWrData_q <= 8'h00;
      end else begin
         ioWrEn_q <= (state_q == cald_pkg::ST_IO_RMW) && ioInRange;
         if (state_q == cald_pkg::ST_IO_RMW) begin
            ioWrAddr_q <= ioAddr_q;
            ioWrData_q <= ioRmwData;
         end
      end
   end

   // completion and refusal pulses
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         opDone_q   <= 1'b0;
         opReject_q <= 1'b0;
      end else begin
         opDone_q   <= byteWr || (state_q != cald_pkg::ST_IDLE);
         opReject_q <= accept && isIoOp(opCode) && !ioReqInRange;
      end
   end

   assign opDone      = opDone_q;
   assign opReject    = opReject_q;
   assign statusFlags = flags_q;
   assign regPeekData = regs_q[regPeekAddr];
   assign ioRdAddr    = ioAddr_q;
   assign ioWrEn      = ioWrEn_q;
   assign ioWrAddr    = ioWrAddr_q;
   assign ioWrData    = ioWrData_q;

endmodule : cald_datapath

`default_nettype wire

// File: cald_map.svh
// Purpose: constants of the arithmetic and logic datapath
// Assumes: included by bare name from the datapath files, not from the package
// Notes:   status byte layout, reset values, reach of the io bit ops, clock counts
`ifndef CALD_MAP_SVH
`define CALD_MAP_SVH

// status byte bit positions
`define CALD_FLAG_C        3
`define CALD_FLAG_Z        1
`define CALD_FLAG_N        2
`define CALD_FLAG_V        0
`define CALD_FLAG_S        4
`define CALD_FLAG_H        5
`define CALD_FLAG_T        6
`define CALD_FLAG_I        7

// reset values
`define CALD_FLAGS_RST     8'h00
`define CALD_REG_RST       8'h00

// register file shape
`define CALD_REG_COUNT     32
`define CALD_REG_AW        5

// io bit ops reach only this address window
`define CALD_IO_BIT_LOW    6'h00
`define CALD_IO_BIT_TOP    6'h1F

// execution clocks
`define CALD_BYTE_CLOCKS   1
`define CALD_WORD_CLOCKS   2
`define CALD_IO_CLOCKS     2

`endif

// File: cald_pkg.sv
// Purpose: types shared by the datapath files
// Assumes: cald_map.svh holds the numeric constants
// Notes:   operation codes and sequencer states
`default_nettype none

package cald_pkg;

   typedef enum logic [3:0] {
      OP_ADD                            = 4'h0,
      OP_ADD_WITH_CARRY                 = 4'h1,
      OP_SUBTRACT                       = 4'h2,
      OP_SUBTRACT_IMMEDIATE             = 4'h3,
      OP_SUBTRACT_WITH_BORROW           = 4'h4,
      OP_SUBTRACT_IMMEDIATE_WITH_BORROW = 4'h5,
      OP_AND_IMMEDIATE                  = 4'h6,
      OP_SET_BITS_IMMEDIATE             = 4'h7,
      OP_CLEAR_BITS_IMMEDIATE           = 4'h8,
      OP_WORD_ADD_IMMEDIATE             = 4'h9,
      OP_WORD_SUBTRACT_IMMEDIATE        = 4'hA,
      OP_IO_BIT_SET                     = 4'hB,
      OP_IO_BIT_CLEAR                   = 4'hC
   } cald_op_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_WORD_HI = 2'b01,
      ST_IO_RMW  = 2'b10
   } cald_state_t;

endpackage : cald_pkg

`default_nettype wire

// File: cald_io_bit.sv
// Purpose: read-modify-write byte for the io bit set and clear operations
// Assumes: rdData is the whole current io register, same clock domain
// Notes:   purely combinational; the caller registers the write
`include "cald_map.svh"
`default_nettype none

module cald_io_bit (
   input  wire logic [5:0] ioAddr,
   input  wire logic [2:0] bitIndex,
   input  wire logic       setNotClear,
   input  wire logic [7:0] rdData,
   output logic            inRange,
   output logic [7:0]      wrData
);

   logic [7:0] mask;

   always_comb begin
      mask = 8'h01 << bitIndex;
      inRange = (ioAddr >= `CALD_IO_BIT_LOW) && (ioAddr <= `CALD_IO_BIT_TOP);
      // every other bit is rewritten as read, so a set write-one-to-clear
      // flag goes back as one and is cleared by the peripheral
      if (setNotClear) begin
         wrData = rdData | mask;
      end else begin
         wrData = rdData & ~mask;
      end
   end

endmodule : cald_io_bit

`default_nettype wire

// File: cald_datapath_asserts.sv
// Purpose: port checks on the datapath
// Assumes: bound to cald_datapath, one clock domain
// Notes:   io data checks need the io space answer in the cycle after take
`include "cald_map.svh"
`default_nettype none

module cald_datapath_asserts (
   input wire logic               core_clk,
   input wire logic               arst_n,
   input wire logic               opValid,
   input wire logic               opReady,
   input wire cald_pkg::cald_op_t opCode,
   input wire logic [5:0]         ioAddr,
   input wire logic [2:0]         ioBitIndex,
   input wire logic               opDone,
   input wire logic               opReject,
   input wire logic [7:0]         statusFlags,
   input wire logic [5:0]         ioRdAddr,
   input wire logic [7:0]         ioRdData,
   input wire logic               ioWrEn,
   input wire logic [7:0]         ioWrData
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_take;
      opValid && opReady;
   endsequence
   sequence s_byteTake;
      s_take ##0 (opCode <= cald_pkg::OP_CLEAR_BITS_IMMEDIATE);
   endsequence
   sequence s_wordTake;
      s_take ##0 (opCode inside {cald_pkg::OP_WORD_ADD_IMMEDIATE,
                                 cald_pkg::OP_WORD_SUBTRACT_IMMEDIATE});
   endsequence
   sequence s_ioTake(cald_pkg::cald_op_t code);
      s_take ##0 (opCode == code) ##0 (ioAddr <= `CALD_IO_BIT_TOP);
   endsequence

   property p_byteDone;
      s_byteTake |=> opDone;
   endproperty
   property p_wordDone;
      s_wordTake |=> !opReady && !opDone ##1 opDone && opReady;
   endproperty
   property p_byteKeepS;
      s_byteTake |=> statusFlags[`CALD_FLAG_S] == $past(statusFlags[`CALD_FLAG_S]);
   endproperty
   property p_wordKeepH;
      s_wordTake |-> ##2 statusFlags[`CALD_FLAG_H] == $past(statusFlags[`CALD_FLAG_H], 2);
   endproperty
   property p_logicFlags;
      s_take ##0 (opCode inside {cald_pkg::OP_AND_IMMEDIATE, cald_pkg::OP_SET_BITS_IMMEDIATE,
                                 cald_pkg::OP_CLEAR_BITS_IMMEDIATE})
         |=> (statusFlags & 8'h38) == ($past(statusFlags) & 8'h38) && !statusFlags[`CALD_FLAG_V];
   endproperty
   property p_ioSet;
      s_ioTake(cald_pkg::OP_IO_BIT_SET) |=> ioRdAddr == $past(ioAddr) ##1
         ioWrEn && opDone && ioWrData == ($past(ioRdData) | (8'h01 << $past(ioBitIndex, 2)));
   endproperty
   property p_ioClear;
      s_ioTake(cald_pkg::OP_IO_BIT_CLEAR) |=> ioRdAddr == $past(ioAddr) ##1
         ioWrEn && opDone && ioWrData == ($past(ioRdData) & ~(8'h01 << $past(ioBitIndex, 2)));
   endproperty
   property p_ioReject;
      s_take ##0 (opCode inside {cald_pkg::OP_IO_BIT_SET, cald_pkg::OP_IO_BIT_CLEAR})
         ##0 (ioAddr > `CALD_IO_BIT_TOP) |=> (opReject && !ioWrEn) ##1 !ioWrEn;
   endproperty
   property p_flagsTop;
      statusFlags[7:6] == 2'b00;
   endproperty

   a_byteDone: assert property (p_byteDone) else $error("byte op not done next cycle");
   a_wordDone: assert property (p_wordDone) else $error("word op timing wrong");
   a_byteKeepS: assert property (p_byteKeepS) else $error("byte op moved S");
   a_wordKeepH: assert property (p_wordKeepH) else $error("word op moved H");
   a_logicFlags: assert property (p_logicFlags) else $error("logic op flags wrong");
   a_ioSet: assert property (p_ioSet) else $error("io set rewrite wrong");
   a_ioClear: assert property (p_ioClear) else $error("io clear rewrite wrong");
   a_ioReject: assert property (p_ioReject) else $error("io op out of reach not refused");
   a_flagsTop: assert property (p_flagsTop) else $error("unused status bits set");
endmodule : cald_datapath_asserts

bind cald_datapath cald_datapath_asserts u_chk (
   .core_clk(core_clk), .arst_n(arst_n), .opValid(opValid), .opReady(opReady),
   .opCode(opCode), .ioAddr(ioAddr), .ioBitIndex(ioBitIndex), .opDone(opDone),
   .opReject(opReject), .statusFlags(statusFlags), .ioRdAddr(ioRdAddr),
   .ioRdData(ioRdData), .ioWrEn(ioWrEn), .ioWrData(ioWrData)
);

`default_nettype wire

// File: cald_io_model.sv
// Purpose: io register space behind the io bit operations
// Assumes: read data combinational from the registered read address
// Notes:   one address holds write-one-to-clear flags
`default_nettype none

module cald_io_model #(
   parameter logic [5:0] FLAG_ADDR = 6'h0E,
   parameter logic [7:0] FLAG_MASK = 8'hC0
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic [5:0] ioRdAddr,
   output logic [7:0]      ioRdData,
   input  wire logic       ioWrEn,
   input  wire logic [5:0] ioWrAddr,
   input  wire logic [7:0] ioWrData
);
   logic [7:0] mem [64];

   assign ioRdData = mem[ioRdAddr];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 64; i++) begin
            mem[i] <= (6'(i) == FLAG_ADDR) ? 8'hC5 : {2'b10, 6'(i)};
         end
      end else if (ioWrEn && ioWrAddr == FLAG_ADDR) begin
         // written ones clear flags
         mem[ioWrAddr] <= (ioWrData & ~FLAG_MASK) | (mem[ioWrAddr] & FLAG_MASK & ~ioWrData);
      end else if (ioWrEn) begin
         mem[ioWrAddr] <= ioWrData;
      end
   end
endmodule : cald_io_model

`default_nettype wire

// File: cald_datapath_bench.sv
// Purpose: self-checking bench of the datapath
// Assumes: io model answers reads, reset held two cycles
// Notes:   table rows chain the carry flag from one op to the next
`default_nettype none

module cald_datapath_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      cald_pkg::cald_op_t op;
      logic [7:0]         a;
      logic [7:0]         b;
      logic [5:0]         k;
   } cald_row_t;

   logic               core_clk, arst_n, opValid, opReady, opDone, opReject, regLoadEn, ioWrEn;
   cald_pkg::cald_op_t opCode;
   logic [4:0]         dstSel, srcSel, regLoadAddr, regPeekAddr;
   logic [7:0]         immValue, regLoadData, regPeekData, statusFlags, ioRdData, ioWrData;
   logic [5:0]         ioAddr, ioRdAddr, ioWrAddr;
   logic [2:0]         ioBitIndex;
   logic [7:0]         expF;
   logic [15:0]        expR;
   int                 nMismatch, checked, cyc;
   cald_row_t          rows [13];

   cald_datapath uut (.core_clk(core_clk), .arst_n(arst_n), .opValid(opValid),
      .opReady(opReady), .opCode(opCode), .dstSel(dstSel), .srcSel(srcSel),
      .immValue(immValue), .ioAddr(ioAddr), .ioBitIndex(ioBitIndex), .opDone(opDone),
      .opReject(opReject), .regLoadEn(regLoadEn), .regLoadAddr(regLoadAddr),
      .regLoadData(regLoadData), .regPeekAddr(regPeekAddr), .regPeekData(regPeekData),
      .statusFlags(statusFlags), .ioRdAddr(ioRdAddr), .ioRdData(ioRdData),
      .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr), .ioWrData(ioWrData));
   cald_io_model ioSpace (.core_clk(core_clk), .arst_n(arst_n), .ioRdAddr(ioRdAddr),
      .ioRdData(ioRdData), .ioWrEn(ioWrEn), .ioWrAddr(ioWrAddr), .ioWrData(ioWrData));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         nMismatch++;
         end_sim();
      end
   end

   task end_sim();
      $display("mismatches %0d comparisons %0d", nMismatch, checked);
      if (nMismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         nMismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task ld(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regLoadEn <= 1'b1;
      regLoadAddr <= a;
      regLoadData <= d;
      @(posedge core_clk);
      regLoadEn <= 1'b0;
   endtask : ld

   task peek(input logic [4:0] a);
      @(posedge core_clk);
      regPeekAddr <= a;
      @(negedge core_clk);
   endtask : peek

   task op_go(input cald_pkg::cald_op_t op, input logic [4:0] d, input logic [7:0] k,
              input logic [5:0] a, input logic [2:0] b);
      int n;
      @(posedge core_clk);
      opValid <= 1'b1;
      opCode <= op;
      dstSel <= d;
      srcSel <= 5'h11;
      immValue <= k;
      ioAddr <= a;
      ioBitIndex <= b;
      @(posedge core_clk);
      opValid <= 1'b0;
      n = 0;
      @(negedge core_clk);
      while (!(opDone === 1'b1 || opReject === 1'b1) && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      chk({7'h00, opDone | opReject}, 8'h01);
   endtask : op_go

   function automatic void model(input cald_row_t r);
      logic [8:0]  s;
      logic [4:0]  h;
      logic [16:0] w;
      logic        ci;
      ci = expF[3] && (r.op inside {cald_pkg::OP_ADD_WITH_CARRY,
         cald_pkg::OP_SUBTRACT_WITH_BORROW, cald_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW});
      s = {1'b0, r.a} + {1'b0, r.b} + {8'h00, ci};
      h = {1'b0, r.a[3:0]} + {1'b0, r.b[3:0]} + {4'h0, ci};
      expF[0] = (r.a[7] == r.b[7]) && (s[7] != r.a[7]);
      if (r.op inside {[cald_pkg::OP_SUBTRACT : cald_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW]}) begin
         s = {1'b0, r.a} - {1'b0, r.b} - {8'h00, ci};
         h = {1'b0, r.a[3:0]} - {1'b0, r.b[3:0]} - {4'h0, ci};
         expF[0] = (r.a[7] != r.b[7]) && (s[7] != r.a[7]);
      end
      if (r.op <= cald_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW) begin
         expF[3] = s[8];
         expF[5] = h[4];
      end else if (r.op <= cald_pkg::OP_CLEAR_BITS_IMMEDIATE) begin
         s[7:0] = (r.op == cald_pkg::OP_AND_IMMEDIATE) ? r.a & r.b :
                  (r.op == cald_pkg::OP_SET_BITS_IMMEDIATE) ? r.a | r.b : r.a & ~r.b;
         expF[0] = 1'b0;
      end
      expF[2] = s[7];
      expF[1] = s[7:0] == 8'h00;
      expR = {8'h00, s[7:0]};
      if (r.op >= cald_pkg::OP_WORD_ADD_IMMEDIATE) begin
         w = (r.op == cald_pkg::OP_WORD_ADD_IMMEDIATE) ? {1'b0, r.b, r.a} + {11'h0, r.k}
                                                       : {1'b0, r.b, r.a} - {11'h0, r.k};
         expF[0] = (r.op == cald_pkg::OP_WORD_ADD_IMMEDIATE) ? ~r.b[7] & w[15] : r.b[7] & ~w[15];
         expF[3] = (r.op == cald_pkg::OP_WORD_ADD_IMMEDIATE) ? ~w[15] & r.b[7] : w[15] & ~r.b[7];
         expF[2] = w[15];
         expF[1] = w[15:0] == 16'h0000;
         expF[4] = w[15] ^ expF[0];
         expR = w[15:0];
      end
   endfunction : model

   task run_row(input cald_row_t r);
      logic wd;
      wd = r.op >= cald_pkg::OP_WORD_ADD_IMMEDIATE;
      ld(wd ? 5'h18 : 5'h10, r.a);
      ld(wd ? 5'h19 : 5'h11, r.b);
      // odd select still picks the even pair
      op_go(r.op, wd ? 5'h19 : 5'h10, wd ? {2'h0, r.k} : r.b, 6'h00, 3'h0);
      model(r);
      chk(statusFlags, expF);
      peek(wd ? 5'h18 : 5'h10);
      chk(regPeekData, expR[7:0]);
      if (wd) begin
         peek(5'h19);
         chk(regPeekData, expR[15:8]);
      end
   endtask : run_row

   initial begin
      {arst_n, opValid, regLoadEn, dstSel, srcSel, regLoadAddr, regPeekAddr} = '0;
      {immValue, regLoadData, ioAddr, ioBitIndex, nMismatch, checked, cyc} = '0;
      opCode = cald_pkg::OP_ADD;
      rows = '{'{cald_pkg::OP_ADD, 8'h8F, 8'h71, 6'h00},
               '{cald_pkg::OP_ADD_WITH_CARRY, 8'h0F, 8'h30, 6'h00},
               '{cald_pkg::OP_SUBTRACT, 8'h80, 8'h01, 6'h00},
               '{cald_pkg::OP_SUBTRACT_IMMEDIATE, 8'h10, 8'h20, 6'h00},
               '{cald_pkg::OP_SUBTRACT_WITH_BORROW, 8'h50, 8'h10, 6'h00},
               '{cald_pkg::OP_SUBTRACT_IMMEDIATE, 8'h00, 8'h01, 6'h00},
               '{cald_pkg::OP_SUBTRACT_IMMEDIATE_WITH_BORROW, 8'h22, 8'h11, 6'h00},
               '{cald_pkg::OP_AND_IMMEDIATE, 8'hF0, 8'h8C, 6'h00},
               '{cald_pkg::OP_SET_BITS_IMMEDIATE, 8'h00, 8'h00, 6'h00},
               '{cald_pkg::OP_CLEAR_BITS_IMMEDIATE, 8'hFF, 8'hF0, 6'h00},
               '{cald_pkg::OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'h7F, 6'h3F},
               '{cald_pkg::OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 6'h01},
               '{cald_pkg::OP_WORD_ADD_IMMEDIATE, 8'hC1, 8'hFF, 6'h3F}};
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      @(negedge core_clk);
      chk({7'h00, opReady}, 8'h01);
      chk(statusFlags, 8'h00);
      expF = 8'h00;
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      // back to back adds, second sees the first result
      ld(5'h10, 8'h01);
      ld(5'h11, 8'h02);
      @(posedge core_clk);
      opValid <= 1'b1;
      opCode <= cald_pkg::OP_ADD;
      dstSel <= 5'h10;
      @(posedge core_clk);
      @(negedge core_clk);
      chk({7'h00, opDone}, 8'h01);
      @(posedge core_clk);
      opValid <= 1'b0;
      @(negedge core_clk);
      chk({7'h00, opDone}, 8'h01);
      peek(5'h10);
      chk(regPeekData, 8'h05);
      // io bit ops reach addresses 00 to 1F only
      op_go(cald_pkg::OP_IO_BIT_SET, 5'h00, 8'h00, 6'h0E, 3'h0);
      chk(ioWrData, 8'hC5);
      @(negedge core_clk);
      chk(ioSpace.mem[14], 8'h05);
      op_go(cald_pkg::OP_IO_BIT_CLEAR, 5'h00, 8'h00, 6'h1F, 3'h7);
      chk({7'h00, ioWrEn}, 8'h01);
      chk(ioWrData, 8'h1F);
      op_go(cald_pkg::OP_IO_BIT_SET, 5'h00, 8'h00, 6'h21, 3'h0);
      chk({6'h00, ioWrEn, opReject}, 8'h01);
      @(negedge core_clk);
      chk(ioSpace.mem[33], 8'hA1);
      // undefined code is ignored
      @(posedge core_clk);
      opValid <= 1'b1;
      opCode <= cald_pkg::cald_op_t'(4'hD);
      dstSel <= 5'h10;
      @(posedge core_clk);
      opValid <= 1'b0;
      @(negedge core_clk);
      chk({7'h00, opDone}, 8'h00);
      peek(5'h10);
      chk(regPeekData, 8'h05);
      end_sim();
   end
endmodule : cald_datapath_bench

`default_nettype wire
